// ### rtl/ssfa_fetch_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`include "ssfa_cfg.svh"

// Summary of operation
// - first-region line count is low byte plus two low bits of high byte
// - a line count at or beyond panel height shows the first region only
// - each frame starts fetching at the first-region start offset, or at the second when the line count is zero in landscape
// - in landscape, after the line count the rest of the frame uses the second offset
// - first region on top unless its line count is zero in landscape; the two offsets have no ordering
// - second start is fifteen bits; top bit of high byte reserved
// - a unit offset change moves the image one to sixteen pixels
// - rotated mode never splits and ignores the second offset
// - only rotated eight-bit mode steps exactly one pixel per unit
// - offset equals high byte times 256 plus low byte
// - split may fall at any line, set only by the line count
// - first start is fifteen bits, top-left word in landscape
// - a word holds 16, 8, 4 or 2 pixels per colour depth
// - rotated mode treats the first start offset as a byte offset
module ssfa_fetch_top (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic frame_start_in,
	input wire logic line_done_in,
	input wire logic vblank_start_in,
	output logic [15:0] fetch_addr_out,
	output logic fetch_active_out,
	output logic second_region_out,
	output logic [9:0] line_index_out,
	output logic [4:0] pixel_step_out
);

	ssfa_pkg::ssfa_cfg_type cfg;
	ssfa_pkg::ssfa_status_type status;
	ssfa_pkg::ssfa_fetch_state_type s_ff;
	ssfa_pkg::ssfa_fetch_state_type nxt_s;
	logic [9:0] line_inc;
	logic split_now;

	////////////////////////////////////////////////////////////////
	// helpers

	// word offset in landscape, byte offset when rotated
	function automatic logic [15:0] to_byte(input logic rot, input logic [14:0] ofs);
		to_byte = rot ? {1'b0, ofs} : {ofs, 1'b0};
	endfunction

	// bytes from one line to the next
	function automatic logic [15:0] stride_bytes(input logic rot, input logic [7:0] st);
		stride_bytes = rot ? {8'h00, st} : {7'h00, st, 1'b0};
	endfunction

	// pixels moved by a unit change of a start offset
	function automatic logic [4:0] pix_step(input logic rot, input logic [1:0] depth);
		pix_step = rot ? (`SSFA_ROT_STEP_1BPP >> depth) : (`SSFA_LAND_STEP_1BPP >> depth);
	endfunction

	////////////////////////////////////////////////////////////////
	// register bank
	ssfa_reg_bank u_regs (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.status_in(status),
		.cfg_out(cfg),
		.rdata_out(rdata_out)
	);

	////////////////////////////////////////////////////////////////
	// line counting and split detection

	// counter saturates so an oversized line count never matches
	assign line_inc = (s_ff.line == `SSFA_LINE_MAX) ? s_ff.line : s_ff.line + 10'h001;
	// split only from the first region, never when rotated
	assign split_now = (s_ff.st == ssfa_pkg::st_first) && !s_ff.lat.rotate
		&& (line_inc == s_ff.lat.s1_lines);

	////////////////////////////////////////////////////////////////
	// fetch sequencer
	always_comb begin
		nxt_s = s_ff;
		case (s_ff.st)
			ssfa_pkg::st_idle: begin
				nxt_s.st = ssfa_pkg::st_idle;
			end
			ssfa_pkg::st_first, ssfa_pkg::st_second: begin
				if (vblank_start_in) begin
					nxt_s.st = ssfa_pkg::st_idle;
				end else if (line_done_in) begin
					nxt_s.line = line_inc;
					if (split_now) begin
						// rest of frame from the second region
						nxt_s.st = ssfa_pkg::st_second;
						nxt_s.addr = to_byte(1'b0, s_ff.lat.s2_start);
					end else begin
						nxt_s.addr = s_ff.addr + stride_bytes(s_ff.lat.rotate, s_ff.lat.stride);
					end
				end
			end
			default: begin
				nxt_s.st = ssfa_pkg::st_idle;
			end
		endcase
		// frame start wins and samples a fresh setup
		if (frame_start_in) begin
			nxt_s.lat = cfg;
			nxt_s.line = 10'h000;
			if (!cfg.rotate && cfg.s1_lines == 10'h000) begin
				nxt_s.st = ssfa_pkg::st_second;
				nxt_s.addr = to_byte(1'b0, cfg.s2_start);
			end else begin
				nxt_s.st = ssfa_pkg::st_first;
				nxt_s.addr = to_byte(cfg.rotate, cfg.s1_start);
			end
		end
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs and status
	assign fetch_addr_out = s_ff.addr;
	assign fetch_active_out = (s_ff.st != ssfa_pkg::st_idle);
	assign second_region_out = (s_ff.st == ssfa_pkg::st_second);
	assign line_index_out = s_ff.line;
	assign pixel_step_out = pix_step(s_ff.lat.rotate, s_ff.lat.depth);
	assign status.second = second_region_out;
	assign status.rotated = s_ff.lat.rotate;
	assign status.line = s_ff.line;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence frame_begin;
		frame_start_in;
	endsequence

	sequence split_step;
		!frame_start_in && !vblank_start_in && line_done_in && split_now;
	endsequence

	sequence plain_step;
		!frame_start_in && !vblank_start_in && line_done_in && !split_now
			&& (s_ff.st != ssfa_pkg::st_idle);
	endsequence

	// frame starts at the first region unless its count is zero in landscape
	a_frame_start_addr: assert property (frame_begin ##0 (cfg.rotate || cfg.s1_lines != 10'h000)
		|=> (s_ff.st == ssfa_pkg::st_first)
		&& fetch_addr_out == to_byte($past(cfg.rotate), $past(cfg.s1_start)))
		else $error("frame did not start at first-region offset");

	// switch to the second region right after the counted lines
	a_split_switch: assert property (split_step |=> second_region_out
		&& fetch_addr_out == {$past(s_ff.lat.s2_start), 1'b0})
		else $error("second region not entered at line count");

	// the switch happens on the exact line the count names
	a_split_line: assert property (split_step |=> line_index_out == s_ff.lat.s1_lines)
		else $error("split on wrong line");

	// rotated frames stay in the first region for their whole length
	a_rot_no_split: assert property (s_ff.lat.rotate |-> !second_region_out)
		else $error("split seen in rotated mode");

	// rotated frames start at a byte offset
	a_rot_byte_ofs: assert property (frame_begin ##0 cfg.rotate
		|=> fetch_addr_out == {1'b0, $past(cfg.s1_start)})
		else $error("rotated start not a byte offset");

	// lines inside a region advance by the stride
	a_line_advance: assert property (plain_step |=> fetch_addr_out
		== $past(s_ff.addr) + stride_bytes(s_ff.lat.rotate, s_ff.lat.stride))
		else $error("line address did not advance by stride");

	// oversized count keeps the whole frame in the first region
	a_no_split_big: assert property ((s_ff.st == ssfa_pkg::st_first) && (s_ff.line == `SSFA_LINE_MAX)
		&& !frame_start_in |=> !second_region_out)
		else $error("split at saturated line count");

	// setup is frozen between frame starts
	a_setup_frozen: assert property (!frame_start_in |=> $stable(s_ff.lat))
		else $error("setup changed inside a frame");

	// pixel step per depth and orientation
	a_step_one_px: assert property (s_ff.lat.rotate && s_ff.lat.depth == 2'h3
		|-> pixel_step_out == 5'h01)
		else $error("rotated 8 bpp step not one pixel");

	a_step_land: assert property (!s_ff.lat.rotate |-> pixel_step_out > 5'h01
		&& pixel_step_out == (5'h10 >> s_ff.lat.depth))
		else $error("landscape step wrong");

	// high byte reserved bits read back as zero
	a_hi_reserved: assert property (rd_in && (addr_in == `SSFA_OFS_S2_HI || addr_in == `SSFA_OFS_S1_HI)
		|=> rdata_out[7] == 1'b0)
		else $error("reserved offset bit read as one");

	a_len_reserved: assert property (rd_in && addr_in == `SSFA_OFS_LINES_HI
		|=> rdata_out[7:2] == 6'h00)
		else $error("line count high bits read as one");

	// offset written as two bytes lands at the next frame
	a_join_offset: assert property (frame_begin ##0 !cfg.rotate && cfg.s1_lines != 10'h000
		|=> fetch_addr_out[15:1] == $past(cfg.s1_start))
		else $error("joined start offset wrong");

endmodule

// ### rtl/ssfa_cfg.svh
`ifndef SSFA_CFG_SVH
`define SSFA_CFG_SVH

// register offsets on the plain register port
`define SSFA_OFS_S1_LO 8'h0c
`define SSFA_OFS_S1_HI 8'h0d
`define SSFA_OFS_S2_LO 8'h0f
`define SSFA_OFS_S2_HI 8'h10
`define SSFA_OFS_LINES_LO 8'h13
`define SSFA_OFS_LINES_HI 8'h14
`define SSFA_OFS_MODE 8'h1b
`define SSFA_OFS_DEPTH 8'h20
`define SSFA_OFS_STATUS 8'h21
`define SSFA_OFS_STRIDE 8'h22
`define SSFA_OFS_LINE_LO 8'h23
`define SSFA_OFS_LINE_HI 8'h24

// field positions
`define SSFA_MODE_ROT_BIT 7
`define SSFA_STATUS_SECOND_BIT 0
`define SSFA_STATUS_ROT_BIT 1

// reset values
`define SSFA_RST_BYTE 8'h00
`define SSFA_RST_HI7 7'h00
`define SSFA_RST_HI2 2'h0
`define SSFA_RST_DEPTH 2'h0
`define SSFA_RST_ROT 1'b0
`define SSFA_READ_NONE 8'h00

// pixels moved by one step of the start offset at one bit per pixel
`define SSFA_LAND_STEP_1BPP 5'h10
`define SSFA_ROT_STEP_1BPP 5'h08
`define SSFA_LINE_MAX 10'h3ff

`endif

// ### rtl/ssfa_pkg.sv
package ssfa_pkg;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_first = 2'b01,
		st_second = 2'b10
	} ssfa_fsm_type;

	// colour depth code: 1, 2, 4, 8 bits per pixel
	typedef enum logic [1:0] {
		depth_1bpp = 2'b00,
		depth_2bpp = 2'b01,
		depth_4bpp = 2'b10,
		depth_8bpp = 2'b11
	} ssfa_depth_type;

	typedef struct packed {
		logic [14:0] s1_start;
		logic [14:0] s2_start;
		logic [9:0] s1_lines;
		logic rotate;
		logic [1:0] depth;
		logic [7:0] stride;
	} ssfa_cfg_type;

	typedef struct packed {
		logic second;
		logic rotated;
		logic [9:0] line;
	} ssfa_status_type;

	typedef struct packed {
		logic [7:0] s1_lo;
		logic [6:0] s1_hi;
		logic [7:0] s2_lo;
		logic [6:0] s2_hi;
		logic [7:0] len_lo;
		logic [1:0] len_hi;
		logic rot;
		logic [1:0] depth;
		logic [7:0] stride;
		logic [7:0] rdata;
	} ssfa_regs_type;

	typedef struct packed {
		ssfa_fsm_type st;
		ssfa_cfg_type lat;
		logic [9:0] line;
		logic [15:0] addr;
	} ssfa_fetch_state_type;

endpackage

// ### rtl/ssfa_reg_bank.sv
`timescale 1ns/1ns
`include "ssfa_cfg.svh"

module ssfa_reg_bank (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire ssfa_pkg::ssfa_status_type status_in,
	output ssfa_pkg::ssfa_cfg_type cfg_out,
	output logic [7:0] rdata_out
);

	ssfa_pkg::ssfa_regs_type r_ff;
	ssfa_pkg::ssfa_regs_type nxt_r;

	// offset is high byte times 256 plus low byte
	function automatic logic [14:0] join_offset(input logic [6:0] hi, input logic [7:0] lo);
		join_offset = {hi, lo};
	endfunction

	////////////////////////////////////////////////////////////////
	// writes and read mux
	always_comb begin
		nxt_r = r_ff;
		nxt_r.rdata = `SSFA_READ_NONE;
		if (wr_in) begin
			case (addr_in)
				`SSFA_OFS_S1_LO: nxt_r.s1_lo = wdata_in;
				`SSFA_OFS_S1_HI: nxt_r.s1_hi = wdata_in[6:0];
				`SSFA_OFS_S2_LO: nxt_r.s2_lo = wdata_in;
				`SSFA_OFS_S2_HI: nxt_r.s2_hi = wdata_in[6:0];
				`SSFA_OFS_LINES_LO: nxt_r.len_lo = wdata_in;
				`SSFA_OFS_LINES_HI: nxt_r.len_hi = wdata_in[1:0];
				`SSFA_OFS_MODE: nxt_r.rot = wdata_in[`SSFA_MODE_ROT_BIT];
				`SSFA_OFS_DEPTH: nxt_r.depth = wdata_in[1:0];
				`SSFA_OFS_STRIDE: nxt_r.stride = wdata_in;
				default: ;
			endcase
		end
		if (rd_in) begin
			case (addr_in)
				`SSFA_OFS_S1_LO: nxt_r.rdata = r_ff.s1_lo;
				`SSFA_OFS_S1_HI: nxt_r.rdata = {1'b0, r_ff.s1_hi};
				`SSFA_OFS_S2_LO: nxt_r.rdata = r_ff.s2_lo;
				`SSFA_OFS_S2_HI: nxt_r.rdata = {1'b0, r_ff.s2_hi};
				`SSFA_OFS_LINES_LO: nxt_r.rdata = r_ff.len_lo;
				`SSFA_OFS_LINES_HI: nxt_r.rdata = {6'h00, r_ff.len_hi};
				`SSFA_OFS_MODE: nxt_r.rdata = {r_ff.rot, 7'h00};
				`SSFA_OFS_DEPTH: nxt_r.rdata = {6'h00, r_ff.depth};
				`SSFA_OFS_STRIDE: nxt_r.rdata = r_ff.stride;
				`SSFA_OFS_STATUS: nxt_r.rdata = {6'h00, status_in.rotated, status_in.second};
				`SSFA_OFS_LINE_LO: nxt_r.rdata = status_in.line[7:0];
				`SSFA_OFS_LINE_HI: nxt_r.rdata = {6'h00, status_in.line[9:8]};
				default: nxt_r.rdata = `SSFA_READ_NONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// register the whole bank
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			r_ff <= '{s1_lo: `SSFA_RST_BYTE, s1_hi: `SSFA_RST_HI7, s2_lo: `SSFA_RST_BYTE,
				s2_hi: `SSFA_RST_HI7, len_lo: `SSFA_RST_BYTE, len_hi: `SSFA_RST_HI2,
				rot: `SSFA_RST_ROT, depth: `SSFA_RST_DEPTH, stride: `SSFA_RST_BYTE,
				rdata: `SSFA_READ_NONE};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// live configuration to the fetch logic
	always_comb begin
		cfg_out.s1_start = join_offset(r_ff.s1_hi, r_ff.s1_lo);
		cfg_out.s2_start = join_offset(r_ff.s2_hi, r_ff.s2_lo);
		cfg_out.s1_lines = {r_ff.len_hi, r_ff.len_lo};
		cfg_out.rotate = r_ff.rot;
		cfg_out.depth = r_ff.depth;
		cfg_out.stride = r_ff.stride;
	end

	assign rdata_out = r_ff.rdata;

endmodule

// ### tb/ssfa_host_model.sv
`timescale 1ns/1ns
// host side of the register port, issuing one-cycle strobes
module ssfa_host_model (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	// idle bus from time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// one write cycle
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	// read data taken in the cycle after the strobe
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		d = rdata_in;
	endtask
	// low byte first, then the quotient by 256
	task automatic set_word(input logic [7:0] lo_a, input logic [15:0] w);
		write_reg(lo_a, w[7:0]);
		write_reg(lo_a + 8'h01, w[15:8]);
	endtask
	// pan or scroll the first start, never below zero
	task automatic move_start(input int cur, input int delta, output int nw);
		nw = (cur + delta < 0) ? 0 : cur + delta;
		set_word(8'h0c, 16'(nw));
	endtask
endmodule

// ### tb/ssfa_fetch_top_tb_top.sv
`timescale 1ns/1ns
module ssfa_fetch_top_tb_top;
	logic clk_in, rst_in, frame_start, line_done, vblank_start, wr, rd, active, second;
	logic [7:0] addr, wdata, rdata, rv;
	logic [15:0] fetch_addr;
	logic [9:0] line_idx;
	logic [4:0] step;
	int error_cnt, num_checks, cycles, nw;
	logic [7:0] ra [4] = '{8'h0f, 8'h10, 8'h13, 8'h14};
	logic [7:0] wa [5] = '{8'h0f, 8'h10, 8'h13, 8'h14, 8'h30};
	logic [7:0] wd [5] = '{8'ha5, 8'hff, 8'h5a, 8'hff, 8'hff};
	logic [7:0] wx [5] = '{8'ha5, 8'h7f, 8'h5a, 8'h03, 8'h00};
	////////////////////////////////////////////////
	ssfa_fetch_top ssfa_fetch_top_inst (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .frame_start_in(frame_start), .line_done_in(line_done),
		.vblank_start_in(vblank_start), .fetch_addr_out(fetch_addr), .fetch_active_out(active),
		.second_region_out(second), .line_index_out(line_idx), .pixel_step_out(step));
	ssfa_host_model ssfa_host_model_inst (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	////////////////////////////////////////////////
	// free-running clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// hang guard
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			$display("unexpected at %0t: run too long", $time);
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////
	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// timing pulse: 0 frame start, 1 line done, else vblank
	task automatic ev(input int k);
		@(posedge clk_in);
		case (k)
			0: frame_start <= 1'b1;
			1: line_done <= 1'b1;
			default: vblank_start <= 1'b1;
		endcase
		@(posedge clk_in);
		frame_start <= 1'b0;
		line_done <= 1'b0;
		vblank_start <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask
	// one frame of n lines with expected byte addresses
	task automatic run_frame(input logic [14:0] s1, input logic [14:0] s2, input int split, input int st,
		input logic rot, input int dep, input int n);
		logic [15:0] exp;
		ev(0);
		chk(16'(step), rot ? 16'(5'h08 >> dep) : 16'(5'h10 >> dep), "step");
		for (int i = 0; i < n; i++) begin
			if (rot) exp = {1'b0, s1};
			else if (i < split) exp = 16'(s1 * 2 + i * st * 2);
			else exp = 16'(s2 * 2 + (i - split) * st * 2);
			if (!rot || i == 0) chk(fetch_addr, exp, "addr");
			chk(16'(second), 16'(!rot && i >= split), "region");
			chk(16'(line_idx), 16'(i), "line index");
			ev(1);
		end
		ev(2);
		chk(16'(active), 16'h0000, "idle");
	endtask
	// verdict
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_in = 1'b1;
		frame_start = 1'b0;
		line_done = 1'b0;
		vblank_start = 1'b0;
		cycles = 0;
		error_cnt = 0;
		num_checks = 0;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		// reset values
		for (int i = 0; i < 4; i++) begin
			ssfa_host_model_inst.read_reg(ra[i], rv);
			chk(16'(rv), 16'h0000, "reset reg");
		end
		chk(16'(step), 16'h0010, "reset step");
		$display("test reset done");
		// reserved bits, unmapped place
		for (int i = 0; i < 5; i++) begin
			ssfa_host_model_inst.write_reg(wa[i], wd[i]);
			ssfa_host_model_inst.read_reg(wa[i], rv);
			chk(16'(rv), 16'(wx[i]), "reg rw");
		end
		$display("test registers done");
		// split with second region lower in memory
		ssfa_host_model_inst.set_word(8'h0c, 16'h0100);
		ssfa_host_model_inst.set_word(8'h0f, 16'h0010);
		ssfa_host_model_inst.set_word(8'h13, 16'h0002);
		ssfa_host_model_inst.write_reg(8'h22, 8'h04);
		run_frame(15'h0100, 15'h0010, 2, 4, 1'b0, 0, 5);
		// boundary at every depth, count 0 included
		for (int d = 0; d < 4; d++) begin
			ssfa_host_model_inst.write_reg(8'h20, 8'(d));
			ssfa_host_model_inst.set_word(8'h13, 16'(d));
			run_frame(15'h0100, 15'h0010, d, 4, 1'b0, d, 4);
		end
		// count at or beyond the panel height
		ssfa_host_model_inst.set_word(8'h13, 16'h0004);
		run_frame(15'h0100, 15'h0010, 4, 4, 1'b0, 3, 4);
		ssfa_host_model_inst.set_word(8'h13, 16'h03ff);
		run_frame(15'h0100, 15'h0010, 1023, 4, 1'b0, 3, 4);
		$display("test split done");
		// rotated: no split, byte offset, one-pixel step at 8 bpp
		ssfa_host_model_inst.set_word(8'h13, 16'h0001);
		ssfa_host_model_inst.write_reg(8'h1b, 8'h80);
		run_frame(15'h0100, 15'h0010, 1, 4, 1'b1, 3, 3);
		ssfa_host_model_inst.write_reg(8'h1b, 8'h00);
		$display("test rotated done");
		// mid-frame update waits for the next frame
		ssfa_host_model_inst.set_word(8'h13, 16'h03ff);
		ev(0);
		chk(fetch_addr, 16'h0200, "frame base");
		ssfa_host_model_inst.move_start(32'h0100, -32'h0101, nw);
		ev(1);
		chk(fetch_addr, 16'h0208, "held setup");
		ssfa_host_model_inst.read_reg(8'h23, rv);
		chk(16'(rv), 16'h0001, "line status");
		ev(2);
		run_frame(15'(nw), 15'h0010, 1023, 4, 1'b0, 3, 2);
		ssfa_host_model_inst.move_start(nw, 32'h0050, nw);
		run_frame(15'(nw), 15'h0010, 1023, 4, 1'b0, 3, 2);
		$display("test update done");
		tally_and_finish();
	end
endmodule
